//--- poq_pkg.sv
/*
 package of the pre-register override queue: register offsets, field
 positions, command codes, status codes and state types.
 assumes one clock domain and a plain register port.
*/
package poq_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;

	// register offsets on the plain port
	localparam logic [3:0] OFS_COMMAND = 4'h0;
	localparam logic [3:0] OFS_MODE_PRELOAD = 4'h1;
	localparam logic [3:0] OFS_TARGET_PRELOAD = 4'h2;
	localparam logic [3:0] OFS_TOP_SPEED_PRELOAD = 4'h3;
	localparam logic [3:0] OFS_ENVIRONMENT_FIVE = 4'h4;
	localparam logic [3:0] OFS_COMPARE5_PRELOAD = 4'h5;
	localparam logic [3:0] OFS_COUNTER1 = 4'h6;
	localparam logic [3:0] OFS_AXIS_STATUS = 4'h7;
	localparam logic [3:0] OFS_MAIN_STATUS = 4'h8;
	localparam logic [3:0] OFS_TARGET_VALUE = 4'h9;
	localparam logic [3:0] OFS_TOP_SPEED_VALUE = 4'hA;
	localparam logic [3:0] OFS_COMPARE5_VALUE = 4'hB;
	localparam logic [3:0] OFS_REMAINING = 4'hC;
	localparam logic [3:0] OFS_MODE_VALUE = 4'hD;

	// command codes
	localparam logic [7:0] CMD_SHIFT_ALL = 8'h2B;
	localparam logic [7:0] CMD_MARK_OVERRIDE = 8'h4F;
	localparam logic [7:0] CMD_START_ACCEL_DECEL = 8'h53;
	localparam logic [7:0] CMD_SYNC_START = 8'h2A;

	// mode preload fields
	localparam int TIMING_LSB = 18;
	localparam logic [1:0] TIMING_WAIT_SYNC = 2'h1;
	localparam int OPMODE_LSB = 0;

	// environment five fields
	localparam int CMP5_COND_LSB = 0;
	localparam int CMP5_ACTION_LSB = 6;
	localparam logic [2:0] CMP5_COND_GE_COUNTER1 = 3'h1;
	localparam logic [1:0] CMP5_ACTION_BULK = 2'h3;

	// status fields
	localparam int COND_LSB = 0;
	localparam int PENDING_LSB = 4;
	localparam int CMP_COUNT_LSB = 6;
	localparam int FULL_BIT = 14;
	localparam int BUSY_BIT = 0;

	localparam logic [3:0] COND_STOPPED = 4'h0;
	localparam logic [3:0] COND_WAIT_SYNC = 4'h2;
	localparam logic [3:0] COND_RUNNING = 4'hF;

	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_TWO = 2'h2;
	localparam logic [1:0] CNT_THREE = 2'h3;

	// one queue stage: data plus its flags
	typedef struct packed {
		logic [DATA_W-1:0] mode;
		logic [DATA_W-1:0] target;
		logic [DATA_W-1:0] speed;
		logic det;
		logic has_start;
	} poq_stage_t;

	// run states, gray along stopped -> waiting -> running
	typedef enum logic [1:0] {
		POQ_STOPPED = 2'b00,
		POQ_WAITING = 2'b01,
		POQ_RUNNING = 2'b11
	} poq_run_t;

endpackage

//--- poq_sync.sv
/*
 two flip-flop synchroniser for one pin level.
 assumes the pin is asynchronous to mclk_in.
*/
`timescale 1ns/1ps
module poq_sync (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic pin_in,
	output logic level_out
);
	typedef struct packed {
		logic meta;
		logic stable;
	} poq_sync_state_t;

	poq_sync_state_t state_reg;
	poq_sync_state_t state_next;

	always_comb begin
		state_next.meta = pin_in;
		state_next.stable = state_reg.meta;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign level_out = state_reg.stable;
endmodule

//--- poq_cmp_queue.sv
/*
 comparator 5 compare-value queue: active value plus one preload stage.
 assumes push and advance pulses come from logic on mclk_in.
*/
`timescale 1ns/1ps
module poq_cmp_queue (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic push_in,
	input wire logic [poq_pkg::DATA_W-1:0] value_in,
	input wire logic advance_in,
	output logic [poq_pkg::DATA_W-1:0] active_out,
	output logic [1:0] count_out
);
	typedef struct packed {
		logic [poq_pkg::DATA_W-1:0] active;
		logic [poq_pkg::DATA_W-1:0] pre;
		logic [1:0] count;
	} poq_cq_state_t;

	poq_cq_state_t state_reg;
	poq_cq_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (advance_in) begin
			state_next.active = state_reg.pre; // R16
			if (state_reg.count != poq_pkg::CNT_ZERO) begin
				state_next.count = state_reg.count - poq_pkg::CNT_ONE; // R16
			end
		end
		// a push while advancing lands after the advance
		if (push_in) begin
			if (state_next.count == poq_pkg::CNT_ZERO) begin
				state_next.active = value_in; // R15
				state_next.count = poq_pkg::CNT_TWO;
			end else if (state_next.count == poq_pkg::CNT_ONE) begin
				state_next.pre = value_in; // R15
				state_next.count = poq_pkg::CNT_TWO;
			end else begin
				state_next.pre = value_in;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign active_out = state_reg.active;
	assign count_out = state_reg.count;
endmodule

//--- poq_top.sv
/*
 pre-register override queue of one axis: second pre-register, first
 pre-register and current register, with shift, override and chaining.
 assumes a plain register port on mclk_in and an external pulse engine
 that reports completion; the sync start pin is asynchronous.
*/
// Overview of operation
// R01: write with all stages undetermined copies into both lower stages
// R02: start with current undetermined determines current, count becomes 01
// R03: start with sync-wait timing enters waiting condition 0010b
// R04: with only current determined, writes copy into first stage only
// R05: mark-override command 4Fh determines lowest undetermined pre-stage, count up
// R06: with first stage determined, writes touch only the second stage
// R07: start with current and first determined fills second, count 11, full flag
// R08: shift-all 2Bh moves stages down, clears full, keeps speed pattern
// R09: completion with determined continuous first stage chains into current and starts
// R10: completion with nothing determined ends operation, count 00
// R11: comparator 5 bulk override with condition 001b shifts like shift-all
// R12: completion before compare match still shifts, then runs continuous data
// R13: shifted override data ends at completion, starts nothing itself
// R14: completion with only override data left clears all, ends operation
// R15: compare preload queue: first write active, next write queued, counted; here the first write already sets count 10
// R16: each bulk override advances compare value and decrements compare count
// R17: bulk override changes active top speed at once
// R18: host must not write the queue while the full flag is set
// R19: bulk override replaces every continuous field at once
// R20: count and full flag readable always, updated with each stage change
`timescale 1ns/1ps
module poq_top (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [poq_pkg::ADDR_W-1:0] addr_in,
	input wire logic [poq_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic sync_start_input_in,
	input wire logic op_done_in,
	output logic [poq_pkg::DATA_W-1:0] rdata_out,
	output logic running_out,
	output logic [poq_pkg::DATA_W-1:0] top_speed_value_out,
	output logic [poq_pkg::DATA_W-1:0] target_value_out,
	output logic [1:0] pending_stage_count_out,
	output logic second_stage_full_flag_out
);
	// all axis state except the synchroniser and compare queue in one register
	typedef struct packed {
		poq_pkg::poq_stage_t cur;
		poq_pkg::poq_stage_t pre1;
		poq_pkg::poq_stage_t pre2;
		poq_pkg::poq_run_t run;
		logic [poq_pkg::DATA_W-1:0] env5;
		logic [poq_pkg::DATA_W-1:0] counter1;
		logic [poq_pkg::DATA_W-1:0] remaining;
		logic [poq_pkg::DATA_W-1:0] rdata;
		logic [1:0] pending;
		logic full;
		logic running;
	} poq_state_t;

	poq_state_t state_reg;
	poq_state_t state_next;

	logic sync_level;
	logic cq_push;
	logic cq_advance;
	logic [poq_pkg::DATA_W-1:0] cmp_active;
	logic [1:0] cmp_count;

	// pin level only; both flops sit in front of any logic
	poq_sync u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.pin_in(sync_start_input_in),
		.level_out(sync_level)
	);

	poq_cmp_queue u_cmp (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.push_in(cq_push),
		.value_in(wdata_in),
		.advance_in(cq_advance),
		.active_out(cmp_active),
		.count_out(cmp_count)
	);

	function automatic logic [1:0] det_count(input poq_pkg::poq_stage_t c,
		input poq_pkg::poq_stage_t p1, input poq_pkg::poq_stage_t p2);
		logic [1:0] n;
		n = {1'b0, c.det} + {1'b0, p1.det};
		n = n + {1'b0, p2.det};
		return n;
	endfunction

	function automatic logic wait_sync(input poq_pkg::poq_stage_t s);
		return s.mode[poq_pkg::TIMING_LSB +: 2] == poq_pkg::TIMING_WAIT_SYNC;
	endfunction

	// bulk override fires once counter 1 has passed the active compare value
	function automatic logic bulk_hit(input logic [poq_pkg::DATA_W-1:0] env,
		input logic [poq_pkg::DATA_W-1:0] cnt, input logic [poq_pkg::DATA_W-1:0] cmp,
		input logic [1:0] queued);
		logic action_ok;
		logic cond_ok;
		action_ok = env[poq_pkg::CMP5_ACTION_LSB +: 2] == poq_pkg::CMP5_ACTION_BULK;
		cond_ok = env[poq_pkg::CMP5_COND_LSB +: 3] == poq_pkg::CMP5_COND_GE_COUNTER1;
		return action_ok && cond_ok && queued != poq_pkg::CNT_ZERO && cnt > cmp; // R11
	endfunction

	// condition code, pending count and compare count in one word
	function automatic logic [poq_pkg::DATA_W-1:0] axis_status_word(
		input poq_pkg::poq_run_t r, input logic [1:0] pend, input logic [1:0] cmpc);
		logic [poq_pkg::DATA_W-1:0] w;
		w = '0;
		case (r)
			poq_pkg::POQ_WAITING: begin
				w[poq_pkg::COND_LSB +: 4] = poq_pkg::COND_WAIT_SYNC;
			end
			poq_pkg::POQ_RUNNING: begin
				w[poq_pkg::COND_LSB +: 4] = poq_pkg::COND_RUNNING;
			end
			default: begin
				w[poq_pkg::COND_LSB +: 4] = poq_pkg::COND_STOPPED;
			end
		endcase
		w[poq_pkg::PENDING_LSB +: 2] = pend;
		w[poq_pkg::CMP_COUNT_LSB +: 2] = cmpc;
		return w;
	endfunction

	function automatic logic [poq_pkg::DATA_W-1:0] main_status_word(input logic full,
		input logic busy);
		logic [poq_pkg::DATA_W-1:0] w;
		w = '0;
		w[poq_pkg::FULL_BIT] = full;
		w[poq_pkg::BUSY_BIT] = busy;
		return w;
	endfunction

	// decode of preload writes, commands, compare pushes and the comparator 5 bulk match
	logic wr_preload;
	logic is_cmd;
	logic [7:0] cmd;
	logic bulk_match;
	logic do_shift;
	logic do_start;

	always_comb begin
		wr_preload = wr_in && (addr_in == poq_pkg::OFS_MODE_PRELOAD
			|| addr_in == poq_pkg::OFS_TARGET_PRELOAD
			|| addr_in == poq_pkg::OFS_TOP_SPEED_PRELOAD);
		is_cmd = wr_in && addr_in == poq_pkg::OFS_COMMAND;
		cmd = wdata_in[7:0];
		bulk_match = state_reg.running
			&& bulk_hit(state_reg.env5, state_reg.counter1, cmp_active, cmp_count); // R11
		do_shift = (is_cmd && cmd == poq_pkg::CMD_SHIFT_ALL) || bulk_match; // R08 R11
		do_start = is_cmd && cmd == poq_pkg::CMD_START_ACCEL_DECEL;
		cq_push = wr_in && addr_in == poq_pkg::OFS_COMPARE5_PRELOAD; // R15
		cq_advance = bulk_match; // R16
	end

	always_comb begin
		state_next = state_reg;
		state_next.rdata = '0;

		if (wr_in) begin
			case (addr_in)
				poq_pkg::OFS_ENVIRONMENT_FIVE: begin
					state_next.env5 = wdata_in;
				end
				poq_pkg::OFS_COUNTER1: begin
					state_next.counter1 = wdata_in;
				end
				default: begin
				end
			endcase
		end

		// preload writes land in stage 2, copied down while lower stages are open
		if (wr_preload) begin
			case (addr_in)
				poq_pkg::OFS_MODE_PRELOAD: begin
					state_next.pre2.mode = wdata_in;
				end
				poq_pkg::OFS_TARGET_PRELOAD: begin
					state_next.pre2.target = wdata_in;
				end
				default: begin
					state_next.pre2.speed = wdata_in;
				end
			endcase
			if (!state_reg.pre1.det) begin
				state_next.pre1 = state_next.pre2; // R04
				state_next.pre1.det = 1'b0;
				state_next.pre1.has_start = 1'b0;
				if (!state_reg.cur.det) begin
					state_next.cur = state_next.pre2; // R01
					state_next.cur.det = 1'b0;
					state_next.cur.has_start = 1'b0;
				end
			end // R06: pre1 determined, stage 2 only
		end

		// a start with all three stages determined is ignored
		if (do_start) begin
			if (!state_reg.cur.det) begin
				state_next.cur.det = 1'b1; // R02
				state_next.cur.has_start = 1'b1;
				if (wait_sync(state_reg.cur)) begin
					state_next.run = poq_pkg::POQ_WAITING; // R03
				end else begin
					state_next.run = poq_pkg::POQ_RUNNING;
				end
			end else if (!state_reg.pre1.det) begin
				state_next.pre1.det = 1'b1;
				state_next.pre1.has_start = 1'b1;
			end else if (!state_reg.pre2.det) begin
				state_next.pre2.det = 1'b1; // R07
				state_next.pre2.has_start = 1'b1;
			end
		end

		if (is_cmd && cmd == poq_pkg::CMD_MARK_OVERRIDE) begin
			if (!state_reg.pre1.det) begin
				state_next.pre1.det = 1'b1; // R05
				state_next.pre1.has_start = 1'b0;
			end else if (!state_reg.pre2.det) begin
				state_next.pre2.det = 1'b1; // R05
				state_next.pre2.has_start = 1'b0;
			end
		end

		// waiting ends by command or by the synchronised pin
		if (is_cmd && cmd == poq_pkg::CMD_SYNC_START
			&& state_reg.run == poq_pkg::POQ_WAITING) begin
			state_next.run = poq_pkg::POQ_RUNNING;
		end
		if (sync_level && state_reg.run == poq_pkg::POQ_WAITING) begin
			state_next.run = poq_pkg::POQ_RUNNING; // R03
		end

		// shift keeps the running speed pattern; only fields move
		if (do_shift && state_reg.pre1.det) begin
			state_next.cur = state_reg.pre1; // R08 R17 R19
			state_next.cur.has_start = state_reg.cur.has_start && state_reg.pre1.has_start;
			state_next.pre1 = state_reg.pre2;
			state_next.pre2.det = 1'b0;
			state_next.pre2.has_start = 1'b0;
		end

		// completion: override data never starts on its own
		if (op_done_in && state_reg.run == poq_pkg::POQ_RUNNING && !do_shift) begin
			if (state_reg.pre1.det && state_reg.pre1.has_start) begin
				state_next.cur = state_reg.pre1; // R09 R12
				state_next.pre1 = state_reg.pre2;
				state_next.pre2.det = 1'b0;
				state_next.pre2.has_start = 1'b0;
				if (wait_sync(state_reg.pre1)) begin
					state_next.run = poq_pkg::POQ_WAITING;
				end
			end else if (state_reg.pre1.det && state_reg.cur.has_start) begin
				// started data still hands over to queued override data
				state_next.cur = state_reg.pre1; // R12
				state_next.cur.has_start = 1'b0;
				state_next.pre1 = state_reg.pre2;
				state_next.pre2.det = 1'b0;
				state_next.pre2.has_start = 1'b0;
			end else begin
				state_next.cur.det = 1'b0; // R10 R13 R14
				state_next.pre1.det = 1'b0;
				state_next.pre2.det = 1'b0;
				state_next.run = poq_pkg::POQ_STOPPED;
			end
		end

		// status follows the stage flags in the same cycle
		state_next.pending = det_count(state_next.cur, state_next.pre1, state_next.pre2); // R20
		state_next.full = state_next.pre2.det; // R07 R08 R20
		state_next.running = state_next.run == poq_pkg::POQ_RUNNING;
		state_next.remaining = state_next.cur.target;

		// read data stand for one cycle, then drop back to zero
		if (rd_in) begin
			case (addr_in)
				poq_pkg::OFS_AXIS_STATUS: begin
					state_next.rdata = axis_status_word(state_reg.run, state_reg.pending,
						cmp_count); // R20
				end
				poq_pkg::OFS_MAIN_STATUS: begin
					state_next.rdata = main_status_word(state_reg.full, state_reg.running); // R20
				end
				poq_pkg::OFS_MODE_PRELOAD: begin
					state_next.rdata = state_reg.pre2.mode;
				end
				poq_pkg::OFS_TARGET_PRELOAD: begin
					state_next.rdata = state_reg.pre2.target;
				end
				poq_pkg::OFS_TOP_SPEED_PRELOAD: begin
					state_next.rdata = state_reg.pre2.speed;
				end
				poq_pkg::OFS_ENVIRONMENT_FIVE: begin
					state_next.rdata = state_reg.env5;
				end
				poq_pkg::OFS_COUNTER1: begin
					state_next.rdata = state_reg.counter1;
				end
				poq_pkg::OFS_TARGET_VALUE: begin
					state_next.rdata = state_reg.cur.target;
				end
				poq_pkg::OFS_TOP_SPEED_VALUE: begin
					state_next.rdata = state_reg.cur.speed;
				end
				poq_pkg::OFS_COMPARE5_VALUE: begin
					state_next.rdata = cmp_active;
				end
				poq_pkg::OFS_REMAINING: begin
					state_next.rdata = state_reg.remaining;
				end
				poq_pkg::OFS_MODE_VALUE: begin
					state_next.rdata = state_reg.cur.mode;
				end
				default: begin
					state_next.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_out = state_reg.rdata;
	assign running_out = state_reg.running;
	assign top_speed_value_out = state_reg.cur.speed;
	assign target_value_out = state_reg.cur.target;
	assign pending_stage_count_out = state_reg.pending;
	assign second_stage_full_flag_out = state_reg.full;
endmodule

//--- poq_checker_assertions.sv
/*
 port checker of the override queue: count, full flag, read port.
 assumes it is bound to poq_top on one clock.
*/
`timescale 1ns/1ps
module poq_checker (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic op_done_in,
	input wire logic [31:0] rdata_out,
	input wire logic running_out,
	input wire logic [1:0] pending_stage_count_out,
	input wire logic second_stage_full_flag_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	logic cmd;
	logic [7:0] code;
	logic [1:0] pc;
	logic full;
	assign cmd = wr_in && addr_in == poq_pkg::OFS_COMMAND;
	assign code = wdata_in[7:0];
	assign pc = pending_stage_count_out;
	assign full = second_stage_full_flag_out;
	property p_full_three;
		full |-> pc == 2'h3;
	endproperty
	a_full_three: assert property (p_full_three) else $error("full without three stages");
	property p_start_first;
		cmd && code == poq_pkg::CMD_START_ACCEL_DECEL && pc == 2'h0 |-> ##[1:2] pc == 2'h1;
	endproperty
	a_start_first: assert property (p_start_first) else $error("start left count");
	property p_mark;
		cmd && code == poq_pkg::CMD_MARK_OVERRIDE && pc == 2'h1 |-> ##[1:2] pc == 2'h2;
	endproperty
	a_mark: assert property (p_mark) else $error("override mark missed");
	property p_start_third;
		cmd && code == poq_pkg::CMD_START_ACCEL_DECEL && pc == 2'h2 && !op_done_in
			|-> ##[1:2] full;
	endproperty
	a_start_third: assert property (p_start_third) else $error("full flag not set");
	property p_shift;
		cmd && code == poq_pkg::CMD_SHIFT_ALL && full && !op_done_in
			|-> ##[1:2] (!full && pc == 2'h2);
	endproperty
	a_shift: assert property (p_shift) else $error("shift all wrong");
	property p_done_last;
		op_done_in && running_out && pc == 2'h1 && !wr_in |-> ##[1:2] pc == 2'h0;
	endproperty
	a_done_last: assert property (p_done_last) else $error("last stage not released");
	property p_rd_quiet;
		!$past(rd_in) |-> rdata_out == 32'h0;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
	// two quiet cycles rule out any pending stage event except a comparator 5 bulk match
	property p_stable;
		!wr_in && !op_done_in ##1 !wr_in && !op_done_in |=> $stable(pc);
	endproperty
	a_stable: assert property (p_stable) else $error("count moved unprovoked");
	c_full: cover property ($rose(full));
	c_done: cover property (op_done_in && running_out);
	c_shift: cover property (cmd && code == poq_pkg::CMD_SHIFT_ALL && full);
endmodule
bind poq_top poq_checker poq_checker_inst (.mclk_in(mclk_in), .rst_in(rst_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.op_done_in(op_done_in), .rdata_out(rdata_out), .running_out(running_out),
	.pending_stage_count_out(pending_stage_count_out),
	.second_stage_full_flag_out(second_stage_full_flag_out));

//--- poq_host_model.sv
/*
 host model: register port master with write and read tasks.
 assumes the slave never stalls and read data stand one cycle.
*/
`timescale 1ns/1ps
module poq_host_model (
	input wire logic mclk_in,
	input wire logic full_in,
	input wire logic [31:0] rdata_in,
	output logic [3:0] addr_out,
	output logic [31:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial begin
		addr_out = 4'h0;
		wdata_out = 32'h0;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		// queue data is held back while the shared storage is full
		if (full_in && a >= poq_pkg::OFS_MODE_PRELOAD && a <= poq_pkg::OFS_TOP_SPEED_PRELOAD) begin
			$display("host held back a queue write");
		end else begin
			addr_out <= a;
			wdata_out <= d;
			wr_out <= 1'b1;
			@(posedge mclk_in);
			wr_out <= 1'b0;
			addr_out <= ~a;
			wdata_out <= ~d;
		end
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge mclk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		@(posedge mclk_in);
		d = rdata_in;
	endtask
endmodule

//--- tb_top.sv
/*
 testbench of the override queue: chaining, overrides, bulk compare.
 assumes poq_top, the host model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
	logic mclk_in;
	logic rst_in;
	logic sync_pin;
	logic op_done;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic running;
	logic [31:0] speed;
	logic [31:0] target;
	logic [1:0] pend;
	logic full;
	int error_cnt;
	int check_count;
	int cycles;
	logic [31:0] seed;
	logic [31:0] v;
	logic [31:0] d0;
	logic [31:0] d1;
	logic [31:0] d2;
	poq_top poq_top_inst (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .sync_start_input_in(sync_pin), .op_done_in(op_done),
		.rdata_out(rdata), .running_out(running), .top_speed_value_out(speed),
		.target_value_out(target), .pending_stage_count_out(pend),
		.second_stage_full_flag_out(full));
	poq_host_model poq_host_model_inst (.mclk_in(mclk_in), .full_in(full), .rdata_in(rdata),
		.addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task settle;
		repeat (2) @(posedge mclk_in);
		#1;
	endtask
	task w(input logic [3:0] a, input logic [31:0] d);
		poq_host_model_inst.wr(a, d);
		settle;
	endtask
	task cmd(input logic [7:0] c);
		w(poq_pkg::OFS_COMMAND, {24'h0, c});
	endtask
	task st(input logic [1:0] p, input logic f);
		chk("pending", {30'h0, pend}, {30'h0, p});
		chk("full", {31'h0, full}, {31'h0, f});
	endtask
	task done;
		@(posedge mclk_in);
		op_done <= 1'b1;
		@(posedge mclk_in);
		op_done <= 1'b0;
		settle;
	endtask
	task run;
		@(posedge mclk_in);
		sync_pin <= 1'b1;
		for (int i = 0; i < 20 && running !== 1'b1; i++) @(posedge mclk_in);
		#1;
		chk("running", {31'h0, running}, 32'h1);
	endtask
	task do_reset;
		@(posedge mclk_in);
		rst_in <= 1'b1;
		sync_pin <= 1'b0;
		repeat (6) @(posedge mclk_in);
		rst_in <= 1'b0;
		settle;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	initial begin
		rst_in = 1'b1;
		sync_pin = 1'b0;
		op_done = 1'b0;
		error_cnt = 0;
		check_count = 0;
		cycles = 0;
		seed = 32'h23;
		do_reset;
		// chaining with one override mark and a shift
		d0 = xs();
		d1 = xs();
		d2 = xs();
		w(poq_pkg::OFS_MODE_PRELOAD, 32'h0004_0041);
		w(poq_pkg::OFS_TARGET_PRELOAD, d0);
		chk("target", target, d0);
		st(2'h0, 1'b0);
		cmd(poq_pkg::CMD_START_ACCEL_DECEL);
		st(2'h1, 1'b0);
		poq_host_model_inst.rd(poq_pkg::OFS_AXIS_STATUS, v);
		chk("condition", {28'h0, v[3:0]}, {28'h0, poq_pkg::COND_WAIT_SYNC});
		w(poq_pkg::OFS_TARGET_PRELOAD, d1);
		chk("target", target, d0);
		cmd(poq_pkg::CMD_MARK_OVERRIDE);
		st(2'h2, 1'b0);
		w(poq_pkg::OFS_MODE_PRELOAD, 32'h0000_0041);
		w(poq_pkg::OFS_TARGET_PRELOAD, d2);
		chk("target", target, d0);
		cmd(poq_pkg::CMD_START_ACCEL_DECEL);
		st(2'h3, 1'b1);
		run;
		cmd(poq_pkg::CMD_SHIFT_ALL);
		st(2'h2, 1'b0);
		chk("target", target, d1);
		done;
		st(2'h1, 1'b0);
		chk("target", target, d2);
		done;
		st(2'h0, 1'b0);
		chk("running", {31'h0, running}, 32'h0);
		poq_host_model_inst.rd(4'hF, v);
		chk("unmapped", v, 32'h0);
		$display("test chaining done");
		// bulk override at two compare positions
		do_reset;
		w(poq_pkg::OFS_MODE_PRELOAD, 32'h0004_0041);
		w(poq_pkg::OFS_TOP_SPEED_PRELOAD, 32'd200);
		cmd(poq_pkg::CMD_START_ACCEL_DECEL);
		w(poq_pkg::OFS_TOP_SPEED_PRELOAD, 32'd400);
		chk("speed", speed, 32'd200);
		cmd(poq_pkg::CMD_MARK_OVERRIDE);
		w(poq_pkg::OFS_TOP_SPEED_PRELOAD, 32'd800);
		cmd(poq_pkg::CMD_MARK_OVERRIDE);
		st(2'h3, 1'b1);
		w(poq_pkg::OFS_ENVIRONMENT_FIVE, 32'h0000_00C1);
		w(poq_pkg::OFS_COMPARE5_PRELOAD, 32'd250);
		w(poq_pkg::OFS_COMPARE5_PRELOAD, 32'd500);
		w(poq_pkg::OFS_COUNTER1, 32'h0);
		poq_host_model_inst.rd(poq_pkg::OFS_AXIS_STATUS, v);
		chk("cmp count", {30'h0, v[7:6]}, 32'h2);
		cmd(poq_pkg::CMD_SYNC_START);
		chk("running", {31'h0, running}, 32'h1);
		w(poq_pkg::OFS_COUNTER1, 32'd251);
		st(2'h2, 1'b0);
		chk("speed", speed, 32'd400);
		poq_host_model_inst.rd(poq_pkg::OFS_AXIS_STATUS, v);
		chk("cmp count", {30'h0, v[7:6]}, 32'h1);
		w(poq_pkg::OFS_COUNTER1, 32'd501);
		st(2'h1, 1'b0);
		chk("speed", speed, 32'd800);
		poq_host_model_inst.rd(poq_pkg::OFS_COMPARE5_VALUE, v);
		chk("cmp value", v, 32'd500);
		done;
		st(2'h0, 1'b0);
		$display("test bulk done");
		// completion with override data only
		do_reset;
		w(poq_pkg::OFS_MODE_PRELOAD, 32'h0004_0041);
		cmd(poq_pkg::CMD_START_ACCEL_DECEL);
		w(poq_pkg::OFS_TARGET_PRELOAD, d1);
		cmd(poq_pkg::CMD_MARK_OVERRIDE);
		w(poq_pkg::OFS_TARGET_PRELOAD, d2);
		cmd(poq_pkg::CMD_MARK_OVERRIDE);
		run;
		done;
		st(2'h2, 1'b0);
		chk("target", target, d1);
		done;
		st(2'h0, 1'b0);
		chk("running", {31'h0, running}, 32'h0);
		$display("test override end done");
		tally_and_finish;
	end
endmodule
